// file: tpcg_defs.svh
// constants of the two-phase clock generator: counts, taps and reset values
`ifndef TPCG_DEFS_SVH
`define TPCG_DEFS_SVH

// ----------------------------------------------------------------------------
// divider and clock pattern, in oscillator periods
// ----------------------------------------------------------------------------
`define TPCG_CNT_MOD 4'h9
`define TPCG_CNT_LAST 4'h8
`define TPCG_CNT_RST 4'h0
// count held in reset: the all-low slot, so the first phase one is full width
`define TPCG_CNT_INIT 4'h8
`define TPCG_PHI1_START 4'h0
`define TPCG_PHI1_LEN 4'h2
`define TPCG_PHI2_LEN 4'h5
`define TPCG_GAP_LEN 4'h2

// ----------------------------------------------------------------------------
// internal timing taps (counter value one period before the output step)
// ----------------------------------------------------------------------------
`define TPCG_STB_TAP 4'h7
`define TPCG_SYNC_TAP 4'h5

// ----------------------------------------------------------------------------
// reset request conditioning and output reset values
// ----------------------------------------------------------------------------
`define TPCG_HYST_CYCLES 4
`define TPCG_REQ_RST 1'b1
`define TPCG_RESET_OUT_RST 1'b1
`define TPCG_READY_RST 1'b0
`define TPCG_STB_N_RST 1'b1

`endif

// file: tpcg_pkg.sv
// types shared by the two-phase clock generator
`default_nettype none

package tpcg_pkg;
    typedef logic [3:0] tpcg_count_t;

    typedef struct packed {
        logic phi1;
        logic phi2;
        logic phi2_ttl;
    } tpcg_clocks_t;
endpackage

`default_nettype wire

// file: tpcg_hysteresis.sv
// level conditioner: output flips only after the input holds a new level
`default_nettype none
`include "tpcg_defs.svh"

module tpcg_hysteresis
    import tpcg_pkg::*;
#(
    parameter int HYST_CYCLES = `TPCG_HYST_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic level_in,
    output logic level_out_r
);
    localparam int CW = $clog2(HYST_CYCLES + 1);

    logic [CW-1:0] run_r;

    generate
        if (HYST_CYCLES < 1) begin : g_bad
            $error("tpcg_hysteresis: HYST_CYCLES must be at least 1");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // a slow or bouncing edge gives one clean transition
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            run_r <= '0;
            level_out_r <= `TPCG_REQ_RST;
        end else if (level_in == level_out_r) begin
            run_r <= '0;
        end else if (run_r == CW'(HYST_CYCLES - 1)) begin
            run_r <= '0;
            level_out_r <= level_in;
        end else begin
            run_r <= run_r + CW'(1);
        end
    end
endmodule

`default_nettype wire

// file: tpcg_clock_gen.sv
// two-phase processor clock generator with status strobe, reset and ready flops
`default_nettype none
`include "tpcg_defs.svh"

// Function
// - processor clock cycle lasts nine oscillator periods
// - clocks and taps decoded from a synchronous modulo-nine counter
// - clock waveforms follow a two, five, two period pattern
// - every width and delay is a whole number of oscillator periods
// - phase two leads by two periods after phase one leading edge
// - buffered free-running oscillator brought out on its own output
// - logic-level copy of phase two driven on a separate output
// - status strobe formed from cycle-start input and the tap at count seven, in the idle gap
// - strobe asserts once per machine cycle when status is stable
// - strobe asserts six oscillator periods after phase two rises
// - normal strobe pulse lasts one oscillator period
// - strobe held asserted while the reset request is active
// - reset request passed through a hysteresis stage
// - conditioned request sampled on phase-two tap gives active-high reset
// - reset output changes only synchronously with its tap
// - wait request sampled on phase-two tap drives ready output
// - internal decoded taps enable the auxiliary flops and gate the strobe; all flops run on the oscillator clock
module tpcg_clock_gen
    import tpcg_pkg::*;
#(
    parameter int HYST_CYCLES = `TPCG_HYST_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reset_request_n_in,
    input wire logic wait_request_in,
    input wire logic sync_in,
    output logic phi1,
    output logic phi2,
    output logic phi2_ttl,
    output wire logic oscillator_out,
    output logic status_strobe_n,
    output logic reset_out,
    output logic ready_out
);
    tpcg_count_t cnt_r;
    tpcg_count_t cnt_nxt;
    tpcg_clocks_t clk_r;
    tpcg_clocks_t clk_nxt;
    logic strobe_timing_tap;
    logic sync_flop_clock_tap;
    logic req_active;
    logic status_strobe_n_r;
    logic reset_out_r;
    logic ready_out_r;

    generate
        if (HYST_CYCLES < 1) begin : g_bad
            $error("tpcg_clock_gen: HYST_CYCLES must be at least 1");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // divide by nine, free running from the oscillator
    // ------------------------------------------------------------------------
    always_comb begin
        if (cnt_r == `TPCG_CNT_LAST) begin
            cnt_nxt = `TPCG_CNT_RST;
        end else begin
            cnt_nxt = cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= `TPCG_CNT_INIT;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // decode gating: 2 periods phase one, 5 phase two, 2 idle
    // ------------------------------------------------------------------------
    always_comb begin
        clk_nxt.phi1 = (cnt_nxt < `TPCG_PHI1_START + `TPCG_PHI1_LEN);
        clk_nxt.phi2 = (cnt_nxt >= `TPCG_PHI1_START + `TPCG_PHI1_LEN) &&
            (cnt_nxt < `TPCG_PHI1_START + `TPCG_PHI1_LEN + `TPCG_PHI2_LEN);
        clk_nxt.phi2_ttl = clk_nxt.phi2;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clk_r <= '0;
        end else begin
            clk_r <= clk_nxt;
        end
    end

    assign phi1 = clk_r.phi1;
    assign phi2 = clk_r.phi2;
    assign phi2_ttl = clk_r.phi2_ttl;
    assign oscillator_out = clock;

    // ------------------------------------------------------------------------
    // internal timing taps
    // ------------------------------------------------------------------------
    assign strobe_timing_tap = (cnt_r == `TPCG_STB_TAP);
    assign sync_flop_clock_tap = (cnt_r == `TPCG_SYNC_TAP);

    // ------------------------------------------------------------------------
    // reset request conditioning
    // ------------------------------------------------------------------------
    tpcg_hysteresis #(
        .HYST_CYCLES(HYST_CYCLES)
    ) u_hyst (
        .clock(clock),
        .reset_n(reset_n),
        .level_in(!reset_request_n_in),
        .level_out_r(req_active)
    );

    // ------------------------------------------------------------------------
    // status strobe: cycle start gated with the tap, or held by reset
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_strobe_n_r <= `TPCG_STB_N_RST;
        end else begin
            status_strobe_n_r <= !((sync_in && strobe_timing_tap) || req_active);
        end
    end

    assign status_strobe_n = status_strobe_n_r;

    // ------------------------------------------------------------------------
    // reset and ready flops, stepping only on the phase-two tap
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reset_out_r <= `TPCG_RESET_OUT_RST;
        end else if (sync_flop_clock_tap) begin
            reset_out_r <= req_active;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ready_out_r <= `TPCG_READY_RST;
        end else if (sync_flop_clock_tap) begin
            ready_out_r <= wait_request_in;
        end
    end

    assign reset_out = reset_out_r;
    assign ready_out = ready_out_r;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_cycle_length: assert property (
        $rose(phi1) |=> !$rose(phi1)[*8] ##1 $rose(phi1)
    ) else $error("phase one period is not nine oscillator periods");

    a_phi1_width: assert property (
        $rose(phi1) |-> phi1[*2] ##1 !phi1
    ) else $error("phase one width is not two periods");

    a_phi2_lead: assert property (
        $rose(phi1) |-> !phi2[*2] ##0 1 ##1 $rose(phi2)
    ) else $error("phase two does not rise two periods after phase one");

    a_phi2_width: assert property (
        $rose(phi2) |-> phi2[*5] ##1 !phi2[*2] ##1 $rose(phi1)
    ) else $error("phase two width or gap wrong");

    a_no_overlap: assert property (
        !(phi1 && phi2)
    ) else $error("phase clocks overlap");

    a_ttl_copy: assert property (
        phi2_ttl == phi2
    ) else $error("logic-level phase two differs from phase two");

    a_strobe_delay: assert property (
        $rose(phi2) ##5 (sync_in && !req_active) |=> !status_strobe_n
    ) else $error("status strobe not six periods after phase two");

    a_strobe_width: assert property (
        (!status_strobe_n && !req_active && !strobe_timing_tap) |=> status_strobe_n
    ) else $error("status strobe longer than one period");

    a_strobe_once: assert property (
        (!req_active && !(sync_in && strobe_timing_tap)) |=> status_strobe_n
    ) else $error("status strobe asserted outside its tap");

    a_reset_strobe: assert property (
        req_active |=> !status_strobe_n
    ) else $error("status strobe not held during reset request");

    a_reset_sync: assert property (
        $changed(reset_out) |-> $past(sync_flop_clock_tap)
    ) else $error("reset output changed off its tap");

    a_reset_follow: assert property (
        sync_flop_clock_tap |=> reset_out == $past(req_active)
    ) else $error("reset output did not take the conditioned request");

    a_reset_release: assert property (
        $fell(req_active) |-> ##[1:9] !reset_out
    ) else $error("reset output not released within one cycle");

    a_ready_sync: assert property (
        sync_flop_clock_tap |=> ready_out == $past(wait_request_in)
    ) else $error("ready output did not take the wait request");

    a_counter_free: assert property (
        cnt_r == `TPCG_CNT_LAST |=> cnt_r == `TPCG_CNT_RST
    ) else $error("divider did not wrap at nine");

    c_strobe: cover property ($fell(status_strobe_n) && !req_active);
    c_reset_release: cover property ($fell(reset_out));
    c_ready_rise: cover property ($rose(ready_out));
    c_long_strobe: cover property (req_active ##1 !status_strobe_n [*8]);
endmodule

`default_nettype wire

// file: tpcg_cpu_model.sv
// processor-side model: cycle-start pulses and bus grant gating
`default_nettype none
module tpcg_cpu_model (
    input wire logic clock,
    input wire logic phi1,
    input wire logic phi2,
    input wire logic phi2_ttl,
    input wire logic hold_acknowledge,
    input wire logic [2:0] cyc_len,
    output logic sync_in,
    output logic bus_grant
);
    timeunit 1ns;
    timeprecision 1ns;
    logic phi1_q = 1'b0;
    logic phi2_q = 1'b0;
    int n = 0;
    initial sync_in = 1'b0;
    assign bus_grant = hold_acknowledge & phi2_ttl;
    // cycle start raised with phase two, dropped at the next phase one
    always @(posedge clock) begin
        #2;
        if (phi1 && !phi1_q) begin
            sync_in = 1'b0;
            n = n + 1;
        end
        if (phi2 && !phi2_q && n >= cyc_len) begin
            sync_in = 1'b1;
            n = 0;
        end
        phi1_q = phi1;
        phi2_q = phi2;
    end
endmodule
`default_nettype wire

// file: two_phase_clock_generator_tb_top.sv
// self-checking bench of the two-phase clock generator
`default_nettype none
`include "tpcg_defs.svh"
module two_phase_clock_generator_tb_top;
    import tpcg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HYST = 3;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic reset_request_n_in = 1'b0;
    logic wait_request_in = 1'b0;
    logic hold_acknowledge = 1'b0;
    logic [2:0] cyc_len = 3'h3;
    logic sync_in, phi1, phi2, phi2_ttl, oscillator_out;
    logic status_strobe_n, reset_out, ready_out, bus_grant;
    tpcg_count_t cnt;
    logic cond, e_stb, e_rst, e_rdy;
    logic [1:0] ep;
    logic chk = 1'b0;
    int run;
    int fail_count = 0;
    int num_checks = 0;
    always #20 clock = ~clock;
    tpcg_clock_gen #(.HYST_CYCLES(HYST)) u_tpcg_clock_gen (
        .clock(clock), .reset_n(reset_n), .reset_request_n_in(reset_request_n_in),
        .wait_request_in(wait_request_in), .sync_in(sync_in), .phi1(phi1), .phi2(phi2),
        .phi2_ttl(phi2_ttl), .oscillator_out(oscillator_out),
        .status_strobe_n(status_strobe_n), .reset_out(reset_out), .ready_out(ready_out)
    );
    tpcg_cpu_model u_tpcg_cpu_model (
        .clock(clock), .phi1(phi1), .phi2(phi2), .phi2_ttl(phi2_ttl),
        .hold_acknowledge(hold_acknowledge), .cyc_len(cyc_len), .sync_in(sync_in),
        .bus_grant(bus_grant)
    );
    // ------------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------------
    function automatic logic [1:0] exp_phi(tpcg_count_t c);
        return {c < 4'h2, c >= 4'h2 && c <= 4'h6};
    endfunction
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= `TPCG_CNT_INIT;
            cond <= 1'b1;
            run <= 0;
            e_stb <= 1'b1;
            e_rst <= 1'b1;
            e_rdy <= 1'b0;
        end else begin
            cnt <= (cnt == `TPCG_CNT_LAST) ? `TPCG_CNT_RST : cnt + 4'h1;
            e_stb <= !(cond || (cnt == `TPCG_STB_TAP && sync_in === 1'b1));
            if (cnt == `TPCG_SYNC_TAP) begin
                e_rst <= cond;
                e_rdy <= wait_request_in;
            end
            if (reset_request_n_in == cond) begin
                run <= (run == HYST - 1) ? 0 : run + 1;
                if (run == HYST - 1) begin
                    cond <= !cond;
                end
            end else begin
                run <= 0;
            end
        end
    end
    // ------------------------------------------------------------------
    // checks and tasks
    // ------------------------------------------------------------------
    task automatic check_bit(logic got, logic exp, string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        #1;
        if (chk && reset_n) begin
            ep = exp_phi(cnt);
            check_bit(phi1, ep[1], "phi1");
            check_bit(phi2, ep[0], "phi2");
            check_bit(phi2_ttl, ep[0], "phi2_ttl");
            check_bit(bus_grant, hold_acknowledge && ep[0], "grant");
            check_bit(oscillator_out, 1'b1, "oscillator");
            check_bit(status_strobe_n, e_stb, "strobe");
            check_bit(reset_out, e_rst, "reset");
            check_bit(ready_out, e_rdy, "ready");
            #20;
            check_bit(oscillator_out, 1'b0, "oscillator low");
        end
    end
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h5CE3));
        step(2);
        reset_n = 1'b1;
        chk = 1'b1;
        step(13);
        reset_request_n_in = 1'b1;
        step(40);
        $display("test power_up done");
        repeat (900) begin
            step(1);
            wait_request_in = 1'($urandom);
            hold_acknowledge = 1'($urandom);
            reset_request_n_in = ($urandom % 40) != 0;
            if ($urandom % 9 == 0) begin
                cyc_len = 3'h1 + 3'($urandom % 4);
            end
        end
        reset_request_n_in = 1'b1;
        step(30);
        $display("test random done");
        for (int w = 1; w <= HYST + 1; w++) begin
            reset_request_n_in = 1'b0;
            step(w);
            reset_request_n_in = 1'b1;
            step(25);
        end
        $display("test request pulses done");
        step(4);
        reset_n = 1'b0;
        step(1);
        reset_n = 1'b1;
        step(50);
        $display("test second reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
